// ==== inc/sfr_bank_pkg.sv ====
// constants and state layout for the core status, port and power register bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package sfr_bank_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_INDIRECT = 4'h0;
	localparam logic [3:0] IDX_STATUS = 4'h3;
	localparam logic [3:0] IDX_POINTER = 4'h4;
	localparam logic [3:0] IDX_PORT_A = 4'h5;
	localparam logic [3:0] IDX_PORT_B = 4'h6;
	localparam logic [3:0] IDX_POWER = 4'h8;
	localparam logic [3:0] IDX_WAKE = 4'h9;
	localparam logic [3:0] IDX_PC_HIGH = 4'hA;
	localparam logic [3:0] IDX_PULL_LOW = 4'hB;
	localparam logic [3:0] IDX_PULL_HIGH = 4'hC;
	// status field positions
	localparam int ST_CARRY = 0;
	localparam int ST_HALF = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_SPARE = 5;
	localparam int ST_BANK = 6;
	// power control field positions
	localparam int PW_WDT = 7;
	localparam int PW_LVD = 5;
	localparam int PW_PA5_PU = 4;
	localparam int PW_LVR = 3;
	// program-counter buffer field positions
	localparam int PCH_STOP = 6;
	localparam int PCH_W = 3;
	// values after reset
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] POINTER_RST = 8'h00;
	localparam logic [7:0] PORT_A_RST = 8'h00;
	localparam logic [7:0] PORT_B_RST = 8'h00;
	localparam logic [7:0] POWER_RST = 8'h98;
	localparam logic [5:0] WAKE_RST = 6'h3F;
	localparam logic [2:0] PC_HIGH_RST = 3'h0;
	localparam logic [7:0] PULL_LOW_RST = 8'hFF;
	localparam logic [5:0] PULL_HIGH_RST = 6'h3F;

	// whole state of the bank
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] pointer;
		logic [7:0] port_a;
		logic [7:0] port_b;
		logic [7:0] power;
		logic [5:0] wake;
		logic [2:0] pc_high;
		logic [7:0] pull_low;
		logic [5:0] pull_high;
		logic speedup_stop;
		logic ack;
		logic [7:0] rdata;
	} bank_state_t;
endpackage

// ==== verilog/core_status_port_power_sfr_bank.sv ====
// core status, pointer, port data and power-control register bank
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module core_status_port_power_sfr_bank
	import sfr_bank_pkg::*;
#(
	parameter int ADDR_W = 6
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [7:0] writedata,
	output logic [7:0] readdata,
	output logic waitrequest,
	// core events
	input wire logic alu_flag_update,
	input wire logic alu_carry,
	input wire logic alu_half_carry,
	input wire logic alu_zero,
	input wire logic clrwdt_exec,
	input wire logic sleep_exec,
	input wire logic watchdog_timeout,
	input wire logic special_page_access,
	// pins and direction
	input wire logic [7:0] port_a_pins,
	input wire logic [5:0] port_b_pins,
	input wire logic [7:0] port_a_is_output,
	input wire logic [5:0] port_b_is_output,
	input wire logic output_readback_option,
	// control outputs
	output logic [1:0] bank_select,
	output logic [6:0] indirect_pointer,
	output logic [7:0] port_a_latch,
	output logic [5:0] port_b_latch,
	output logic watchdog_enable,
	output logic low_voltage_detect_enable,
	output logic low_voltage_reset_enable,
	output logic pa5_pullup_enable_n,
	output logic [5:0] pin_wake_enable,
	output logic [2:0] pc_high_buffer,
	output logic crystal_speedup_stop,
	output logic [3:0] port_a_pulldown_enable_n,
	output logic [3:0] port_b_pulldown_enable_n,
	output logic [5:0] port_b_pullup_enable_n
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	// constant reset image
	localparam bank_state_t STATE_RST = '{
		status: STATUS_RST, pointer: POINTER_RST, port_a: PORT_A_RST,
		port_b: PORT_B_RST, power: POWER_RST, wake: WAKE_RST,
		pc_high: PC_HIGH_RST, pull_low: PULL_LOW_RST,
		pull_high: PULL_HIGH_RST, speedup_stop: 1'b0, ack: 1'b0,
		rdata: 8'h00};

	bank_state_t cur; // registered state
	bank_state_t next_cur; // next state
	logic req; // request present
	logic take; // request completes this edge
	logic [3:0] target; // effective register index
	logic mapped; // address hits a register
	logic [7:0] rd_value; // read mux output
	logic [7:0] port_a_read; // port A readback
	logic [5:0] port_b_read; // port B readback

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	assign req = read | write;
	// second cycle of a request ends it
	assign take = req & cur.ack;
	assign waitrequest = req & ~cur.ack;

	// resolve indirect access and alignment
	always_comb
	begin
		target = address[5:2];
		mapped = (address[1:0] == 2'h0) && ((address >> 6) == '0);
		// indirect location uses the pointer's low seven bits
		if (target == IDX_INDIRECT)
		begin
			target = cur.pointer[3:0];
			// pointer outside this bank, or itself indirect, hits nothing
			if (cur.pointer[6:4] != 3'h0 || cur.pointer[3:0] == IDX_INDIRECT)
			begin
				mapped = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// port readback
	// ------------------------------------------------------------------
	// output pins return the latch when the option is set, else the pin
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			port_a_read[i] = (port_a_is_output[i] & output_readback_option) ?
				cur.port_a[i] : port_a_pins[i];
		end
		for (int i = 0; i < 6; i++)
		begin
			port_b_read[i] = (port_b_is_output[i] & output_readback_option) ?
				cur.port_b[i] : port_b_pins[i];
		end
	end

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always_comb
	begin
		rd_value = 8'h00;
		if (mapped)
		begin
			unique case (target)
				IDX_STATUS: rd_value = cur.status;
				IDX_POINTER: rd_value = cur.pointer;
				IDX_PORT_A: rd_value = port_a_read;
				// upper two bits are storage, not pins
				IDX_PORT_B: rd_value = {cur.port_b[7:6], port_b_read};
				IDX_POWER: rd_value = cur.power;
				// unused upper bits read zero
				IDX_WAKE: rd_value = {2'h0, cur.wake};
				// write-only register reads zero
				IDX_PC_HIGH: rd_value = 8'h00;
				IDX_PULL_LOW: rd_value = cur.pull_low;
				IDX_PULL_HIGH: rd_value = {2'h0, cur.pull_high};
				default: rd_value = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.speedup_stop = 1'b0;
		// ack for one cycle, then drop so requests never run together
		next_cur.ack = req & ~cur.ack;
		// read value sampled once, in the request's first cycle
		if (req & ~cur.ack)
		begin
			next_cur.rdata = rd_value;
		end
		// software writes land at the edge that ends the request
		if (take & write & mapped)
		begin
			unique case (target)
				// bank, spare and flags all writable
				IDX_STATUS: next_cur.status = writedata;
				IDX_POINTER: next_cur.pointer = writedata;
				IDX_PORT_A: next_cur.port_a = writedata;
				IDX_PORT_B: next_cur.port_b = writedata;
				IDX_POWER: next_cur.power = writedata;
				IDX_WAKE: next_cur.wake = writedata[5:0];
				IDX_PC_HIGH:
				begin
					next_cur.pc_high = writedata[PCH_W-1:0];
					next_cur.speedup_stop = writedata[PCH_STOP];
				end
				IDX_PULL_LOW: next_cur.pull_low = writedata;
				IDX_PULL_HIGH: next_cur.pull_high = writedata[5:0];
				default: next_cur.ack = next_cur.ack;
			endcase
		end
		// arithmetic results override a software write in the same cycle
		if (alu_flag_update)
		begin
			next_cur.status[ST_CARRY] = alu_carry;
			next_cur.status[ST_HALF] = alu_half_carry;
			next_cur.status[ST_ZERO] = alu_zero;
		end
		// clear-watchdog marks both flags high
		if (clrwdt_exec)
		begin
			next_cur.status[ST_PD] = 1'b1;
			next_cur.status[ST_TO] = 1'b1;
		end
		// sleep clears powerdown, sets timeout
		if (sleep_exec)
		begin
			next_cur.status[ST_PD] = 1'b0;
			next_cur.status[ST_TO] = 1'b1;
		end
		// a timeout event is never lost
		if (watchdog_timeout)
		begin
			next_cur.status[ST_TO] = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cur <= STATE_RST;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign readdata = cur.rdata;
	// special pages are always reached with bank zero
	assign bank_select = special_page_access ? 2'h0 :
		cur.status[ST_BANK+1:ST_BANK];
	assign indirect_pointer = cur.pointer[6:0];
	assign port_a_latch = cur.port_a;
	assign port_b_latch = cur.port_b[5:0];
	assign watchdog_enable = cur.power[PW_WDT];
	assign low_voltage_detect_enable = cur.power[PW_LVD];
	assign low_voltage_reset_enable = cur.power[PW_LVR];
	assign pa5_pullup_enable_n = cur.power[PW_PA5_PU];
	assign pin_wake_enable = cur.wake;
	assign pc_high_buffer = cur.pc_high;
	assign crystal_speedup_stop = cur.speedup_stop;
	assign port_a_pulldown_enable_n = cur.pull_low[3:0];
	assign port_b_pulldown_enable_n = cur.pull_low[7:4];
	assign port_b_pullup_enable_n = cur.pull_high;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// carry and zero follow the alu one edge later
	property p_alu_flags;
		@(posedge clk) disable iff (!rst_b)
		alu_flag_update |=> (cur.status[ST_CARRY] == $past(alu_carry)) &&
			(cur.status[ST_ZERO] == $past(alu_zero));
	endproperty
	a_alu_flags: assert property (p_alu_flags)
		else $error("alu flags not captured");

	// half carry follows the alu
	property p_half;
		@(posedge clk) disable iff (!rst_b)
		alu_flag_update |=> cur.status[ST_HALF] == $past(alu_half_carry);
	endproperty
	a_half: assert property (p_half)
		else $error("half carry not captured");

	// sleep without timeout leaves powerdown low, timeout high
	property p_sleep;
		@(posedge clk) disable iff (!rst_b)
		sleep_exec && !watchdog_timeout |=> !cur.status[ST_PD] && cur.status[ST_TO];
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep did not update flags");

	// timeout always clears the timeout flag
	property p_timeout;
		@(posedge clk) disable iff (!rst_b)
		watchdog_timeout |=> !cur.status[ST_TO];
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout flag not cleared");

	// every request is answered on its second cycle
	property p_answer;
		@(posedge clk) disable iff (!rst_b)
		req && !cur.ack |=> !waitrequest || !req;
	endproperty
	a_answer: assert property (p_answer)
		else $error("request not answered in two cycles");

	// a port A write lands in the latch
	property p_port_write;
		@(posedge clk) disable iff (!rst_b)
		take && write && mapped && target == IDX_PORT_A |=> port_a_latch == $past(writedata);
	endproperty
	a_port_write: assert property (p_port_write)
		else $error("port latch not written");

	// write-only buffer reads zero
	property p_wo_read;
		@(posedge clk) disable iff (!rst_b)
		read && !cur.ack && target == IDX_PC_HIGH |=> readdata == 8'h00;
	endproperty
	a_wo_read: assert property (p_wo_read)
		else $error("write-only register read nonzero");

	// speed-up stop is a single-cycle pulse
	property p_stop_pulse;
		@(posedge clk) disable iff (!rst_b)
		crystal_speedup_stop |=> !crystal_speedup_stop;
	endproperty
	a_stop_pulse: assert property (p_stop_pulse)
		else $error("speed-up stop held too long");

	// special page access forces bank zero
	property p_special;
		@(posedge clk) disable iff (!rst_b)
		special_page_access |-> bank_select == 2'h0;
	endproperty
	a_special: assert property (p_special)
		else $error("bank select seen on special page");

	// power enables sit at their reset values after reset
	property p_power_reset;
		@(posedge clk)
		$rose(rst_b) |-> watchdog_enable && !low_voltage_detect_enable &&
			low_voltage_reset_enable && pa5_pullup_enable_n;
	endproperty
	a_power_reset: assert property (p_power_reset)
		else $error("power control reset value wrong");

	// stop bit and counter bits carried by the current write
	logic [3:0] pc_write_bits;
	assign pc_write_bits = {writedata[PCH_STOP], writedata[PCH_W-1:0]};

	// clear-watchdog alone raises both reset-cause flags
	property p_clrwdt;
		@(posedge clk) disable iff (!rst_b)
		clrwdt_exec && !sleep_exec && !watchdog_timeout |=> cur.status[ST_PD] && cur.status[ST_TO];
	endproperty
	a_clrwdt: assert property (p_clrwdt)
		else $error("clear-watchdog did not set flags");

	// status bits 7:3 and pointer bit 7 sit at their reset images
	property p_reset_status;
		@(posedge clk)
		$rose(rst_b) |-> cur.status[7:3] == STATUS_RST[7:3] && cur.pointer[7] == POINTER_RST[7];
	endproperty
	a_reset_status: assert property (p_reset_status)
		else $error("status reset value wrong");

	// wake, buffer and pull controls sit at their reset images
	property p_reset_ctrl;
		@(posedge clk)
		$rose(rst_b) |-> pin_wake_enable == WAKE_RST && pc_high_buffer == PC_HIGH_RST &&
			port_b_pullup_enable_n == PULL_HIGH_RST &&
			{port_b_pulldown_enable_n, port_a_pulldown_enable_n} == PULL_LOW_RST;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl)
		else $error("control reset value wrong");

	// a port B write lands in latch and storage bits
	property p_port_b_write;
		@(posedge clk) disable iff (!rst_b)
		take && write && mapped && target == IDX_PORT_B |=> cur.port_b == $past(writedata);
	endproperty
	a_port_b_write: assert property (p_port_b_write)
		else $error("port B latch not written");

	// a buffer write loads counter bits and the stop strobe
	property p_pc_write;
		@(posedge clk) disable iff (!rst_b)
		take && write && mapped && target == IDX_PC_HIGH |=>
			{crystal_speedup_stop, pc_high_buffer} == $past(pc_write_bits);
	endproperty
	a_pc_write: assert property (p_pc_write)
		else $error("counter buffer not written");

	// counter bits change only through a buffer write
	property p_pc_hold;
		@(posedge clk) disable iff (!rst_b)
		!(take && write && mapped && target == IDX_PC_HIGH) |=> $stable(pc_high_buffer);
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("counter buffer changed without a write");

	// with the option clear, port A reads the pin levels
	property p_readback;
		@(posedge clk) disable iff (!rst_b)
		read && !cur.ack && mapped && target == IDX_PORT_A && !output_readback_option |=>
			readdata == $past(port_a_pins);
	endproperty
	a_readback: assert property (p_readback)
		else $error("port A pin level not read");

	// a status write with no core event lands whole
	property p_status_write;
		@(posedge clk) disable iff (!rst_b)
		take && write && mapped && target == IDX_STATUS && !alu_flag_update && !clrwdt_exec &&
			!sleep_exec && !watchdog_timeout |=> cur.status == $past(writedata);
	endproperty
	a_status_write: assert property (p_status_write)
		else $error("status write lost");

endmodule

// ==== bench/core_bus_model.sv ====
// avalon-mm master model standing in for the processor core
`timescale 1ns/1ps
module core_bus_model
(
	// clock
	input wire logic clk,
	// avalon-mm master side
	output logic [5:0] address,
	output logic read,
	output logic write,
	output logic [7:0] writedata,
	input wire logic [7:0] readdata,
	input wire logic waitrequest
);
	// ----------------------------------------
	// idle levels at time zero
	// ----------------------------------------
	initial
	begin
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 8'h00;
	end
	// one transfer: raised after an edge, held until waitrequest is seen low
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= wd;
		@(posedge clk);
		// hold the request while the slave stalls; only the bench watchdog ends a hang
		while (waitrequest !== 1'b0)
		begin
			@(posedge clk);
		end
		rd = readdata;
		// release; stale lines show the inverse so nothing leans on them
		read <= 1'b0;
		write <= 1'b0;
		writedata <= ~wd;
		address <= ~{idx, 2'b00};
	endtask
endmodule

// ==== bench/core_status_port_power_sfr_bank_tb.sv ====
// self-checking bench for the core status, port and power register bank
`timescale 1ns/1ps
module core_status_port_power_sfr_bank_tb;
	import sfr_bank_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] address;
	logic read, write;
	logic [7:0] writedata, readdata;
	logic waitrequest;
	logic alu_flag_update = 1'b0, alu_carry = 1'b0, alu_half_carry = 1'b0, alu_zero = 1'b0;
	logic clrwdt_exec = 1'b0, sleep_exec = 1'b0, watchdog_timeout = 1'b0;
	logic special_page_access = 1'b0, output_readback_option = 1'b0;
	logic [7:0] port_a_pins = 8'h00, port_a_is_output = 8'h00;
	logic [5:0] port_b_pins = 6'h00, port_b_is_output = 6'h00;
	logic [1:0] bank_select;
	logic [6:0] indirect_pointer;
	logic [7:0] port_a_latch;
	logic [5:0] port_b_latch, pin_wake_enable, port_b_pullup_enable_n;
	logic watchdog_enable, low_voltage_detect_enable, low_voltage_reset_enable;
	logic pa5_pullup_enable_n, crystal_speedup_stop;
	logic [2:0] pc_high_buffer;
	logic [3:0] port_a_pulldown_enable_n, port_b_pulldown_enable_n;
	int mismatches = 0;
	int compares = 0;
	always #10 clk = ~clk;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	core_status_port_power_sfr_bank #(.ADDR_W(6)) core_status_port_power_sfr_bank_i (
		.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.alu_flag_update(alu_flag_update), .alu_carry(alu_carry),
		.alu_half_carry(alu_half_carry), .alu_zero(alu_zero), .clrwdt_exec(clrwdt_exec),
		.sleep_exec(sleep_exec), .watchdog_timeout(watchdog_timeout),
		.special_page_access(special_page_access), .port_a_pins(port_a_pins),
		.port_b_pins(port_b_pins), .port_a_is_output(port_a_is_output),
		.port_b_is_output(port_b_is_output),
		.output_readback_option(output_readback_option),
		.bank_select(bank_select), .indirect_pointer(indirect_pointer),
		.port_a_latch(port_a_latch), .port_b_latch(port_b_latch),
		.watchdog_enable(watchdog_enable),
		.low_voltage_detect_enable(low_voltage_detect_enable),
		.low_voltage_reset_enable(low_voltage_reset_enable),
		.pa5_pullup_enable_n(pa5_pullup_enable_n), .pin_wake_enable(pin_wake_enable),
		.pc_high_buffer(pc_high_buffer), .crystal_speedup_stop(crystal_speedup_stop),
		.port_a_pulldown_enable_n(port_a_pulldown_enable_n),
		.port_b_pulldown_enable_n(port_b_pulldown_enable_n),
		.port_b_pullup_enable_n(port_b_pullup_enable_n));
	core_bus_model core_bus_model_i (.clk(clk), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] r;
		core_bus_model_i.xfer(1'b1, idx, d, r);
		// one more edge so the landed write is settled when outputs are judged
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] idx, output logic [7:0] r);
		core_bus_model_i.xfer(1'b0, idx, 8'h00, r);
	endtask
	// one-cycle core event pulse: {timeout, sleep, clrwdt}
	task automatic ev(input logic [2:0] e);
		@(posedge clk);
		{watchdog_timeout, sleep_exec, clrwdt_exec} <= e;
		@(posedge clk);
		{watchdog_timeout, sleep_exec, clrwdt_exec} <= 3'h0;
	endtask
	task automatic end_sim();
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every register read straight after reset
	task automatic t_reset();
		logic [3:0] ri [10] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
		logic [7:0] rv [10] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h98, 8'h3F, 8'h00,
			8'hFF, 8'h3F};
		logic [7:0] r;
		for (int i = 0; i < 10; i++)
		begin
			rd(ri[i], r);
			chk("reset value", rv[i], r);
		end
		chk("reset outputs", 8'h98, {watchdog_enable, 1'b0, low_voltage_detect_enable,
			pa5_pullup_enable_n, low_voltage_reset_enable, pc_high_buffer});
	endtask
	// arithmetic flags and reset-cause flags
	task automatic t_flags();
		logic [7:0] r;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			alu_flag_update <= 1'b1;
			{alu_zero, alu_half_carry, alu_carry} <= k[2:0];
			@(posedge clk);
			alu_flag_update <= 1'b0;
			rd(IDX_STATUS, r);
			chk("alu flags", {5'h03, k[2:0]}, r);
		end
		ev(3'h2);
		rd(IDX_STATUS, r);
		chk("after sleep", 8'h17, r);
		ev(3'h4);
		rd(IDX_STATUS, r);
		chk("after timeout", 8'h07, r);
		ev(3'h1);
		rd(IDX_STATUS, r);
		chk("after clrwdt", 8'h1F, r);
		ev(3'h5);
		rd(IDX_STATUS, r);
		chk("timeout beats clrwdt", 8'h0F, r);
		ev(3'h1);
	endtask
	// bank codes, spare bit and special-page override
	task automatic t_bank();
		logic [7:0] r;
		for (int b = 0; b < 4; b++)
		begin
			wr(IDX_STATUS, {b[1:0], 6'h3F});
			rd(IDX_STATUS, r);
			chk("status rw", {b[1:0], 6'h3F}, r);
			chk("bank out", {6'h00, b[1:0]}, {6'h00, bank_select});
			@(posedge clk);
			special_page_access <= 1'b1;
			@(posedge clk);
			chk("bank special", 8'h00, {6'h00, bank_select});
			special_page_access <= 1'b0;
		end
	endtask
	// power, wake, pull and counter-buffer registers
	task automatic t_ctrl();
		logic [7:0] pv [3] = '{8'h00, 8'hFF, 8'h67};
		logic [7:0] r;
		for (int i = 0; i < 3; i++)
		begin
			wr(IDX_POWER, pv[i]);
			rd(IDX_POWER, r);
			chk("power rw", pv[i], r);
			chk("power out", {4'h0, pv[i][7], pv[i][5], pv[i][4], pv[i][3]},
				{4'h0, watchdog_enable, low_voltage_detect_enable, pa5_pullup_enable_n,
				low_voltage_reset_enable});
		end
		wr(IDX_WAKE, 8'hEA);
		rd(IDX_WAKE, r);
		chk("wake rw", 8'h2A, r);
		chk("wake out", 8'h2A, {2'h0, pin_wake_enable});
		wr(IDX_PULL_LOW, 8'h5A);
		chk("pull low out", 8'h5A, {port_b_pulldown_enable_n, port_a_pulldown_enable_n});
		wr(IDX_PULL_HIGH, 8'hD5);
		rd(IDX_PULL_HIGH, r);
		chk("pull high rw", 8'h15, r);
		chk("pull high out", 8'h15, {2'h0, port_b_pullup_enable_n});
		wr(IDX_PC_HIGH, 8'h4D);
		chk("pc high out", 8'h05, {5'h00, pc_high_buffer});
		chk("stop pulse", 8'h01, {7'h00, crystal_speedup_stop});
		@(posedge clk);
		chk("stop ends", 8'h00, {7'h00, crystal_speedup_stop});
		rd(IDX_PC_HIGH, r);
		chk("pc high reads 0", 8'h00, r);
		wr(IDX_PC_HIGH, 8'h02);
		chk("no stop", 8'h02, {4'h0, crystal_speedup_stop, pc_high_buffer});
	endtask
	// port latches, read-back option, indirect access and holes
	task automatic t_ports();
		logic [3:0] hole [4] = '{4'h1, 4'h7, 4'hD, 4'hF};
		logic [7:0] r, ea;
		port_a_is_output <= 8'hF0;
		port_b_is_output <= 6'h38;
		port_a_pins <= 8'h3C;
		port_b_pins <= 6'h15;
		wr(IDX_PORT_A, 8'hA5);
		wr(IDX_PORT_B, 8'hC3);
		chk("latch a", 8'hA5, port_a_latch);
		chk("latch b", 8'h03, {2'h0, port_b_latch});
		for (int o = 0; o < 2; o++)
		begin
			output_readback_option <= o[0];
			ea = o[0] ? 8'hAC : 8'h3C;
			rd(IDX_PORT_A, r);
			chk("port a read", ea, r);
			rd(IDX_PORT_B, r);
			chk("port b read", o[0] ? 8'hC5 : 8'hD5, r);
		end
		wr(IDX_POINTER, 8'h85);
		rd(IDX_POINTER, r);
		chk("pointer rw", 8'h85, r);
		chk("pointer out", 8'h05, {1'b0, indirect_pointer});
		rd(IDX_INDIRECT, r);
		chk("indirect read", ea, r);
		wr(IDX_INDIRECT, 8'h3C);
		chk("indirect write", 8'h3C, port_a_latch);
		wr(IDX_POINTER, 8'h10);
		rd(IDX_INDIRECT, r);
		chk("indirect hole", 8'h00, r);
		for (int i = 0; i < 4; i++)
		begin
			wr(hole[i], 8'hFF);
			rd(hole[i], r);
			chk("hole reads 0", 8'h00, r);
		end
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_flags();
		t_bank();
		t_ctrl();
		t_ports();
		// second reset mid-run, pins idle so reads match the reset images
		rst_b <= 1'b0;
		port_a_pins <= 8'h00;
		port_b_pins <= 6'h00;
		port_a_is_output <= 8'h00;
		port_b_is_output <= 6'h00;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		end_sim();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		end_sim();
	end
endmodule
